// File: bench/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import sgt_pkg::*;
;
  // ------------------------------------------------------------
  // Stimulus and observation
  // ------------------------------------------------------------
  localparam int PRE = 16; // Short step keeps the run brief
  localparam int WAKE = 10; // Short wake delay
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  logic hwWatchdogOpt = 1'b0;
  logic usbSuspend = 1'b0;
  logic waitMode = 1'b0;
  sgt_lowpow_type lowPow = '0;
  logic resetPinOut_n;
  logic guardActive;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  logic [7:0] a;
  logic [7:0] b;

  sgt_guard_timer #(.PRESCALE(PRE), .WAKE_CLKS(WAKE)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .hwWatchdogOpt(hwWatchdogOpt), .usbSuspend(usbSuspend),
    .waitMode(waitMode), .lowPow(lowPow), .resetPinOut_n(resetPinOut_n), .guardActive(guardActive));

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  // Hang guard, far above the longest sequence
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Range check, used where the prescaler phase leaves the timing several cycles loose
  task automatic inrange(input int v, input int lo, input int hi);
    chk(8'((v >= lo && v <= hi) ? 1 : 0), 8'h01);
  endtask

  task automatic doreset();
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= ad;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys) regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge clk_sys) regRead <= 1'b0;
    #1 d = regRdata;
  endtask

  // Cycles until the reset pin drops, capped at mx
  task automatic tolow(input int mx, output int c);
    c = 0;
    #1;
    while (resetPinOut_n === 1'b1 && c < mx) begin
      @(posedge clk_sys);
      #1 c++;
    end
  endtask

  // Length of the low pulse
  task automatic lowlen(output int c);
    c = 0;
    while (resetPinOut_n === 1'b0 && c < 200) begin
      @(posedge clk_sys);
      #1 c++;
    end
  endtask

  task automatic halt(input logic osc);
    @(posedge clk_sys);
    lowPow.haltExec <= 1'b1;
    lowPow.oscStop <= osc;
    @(posedge clk_sys) lowPow.haltExec <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    doreset();
    rd(SGT_CTRL_OFFSET, a); chk(a, 8'h7F);
    rd(SGT_MISC_OFFSET, b); chk(b, 8'h00);
    rd(8'h20, b); chk(b, 8'h00);
    chk(8'(guardActive), 8'h00);
    // Inactive counter still steps: two steps in 2*PRE cycles
    rd(SGT_CTRL_OFFSET, a);
    repeat (2 * PRE - 2) @(posedge clk_sys);
    rd(SGT_CTRL_OFFSET, b); chk(b, a - 8'h02);
    // Rollover while inactive never pulls the pin
    tolow(64 * PRE + 50, n); chk(8'(n == 64 * PRE + 50), 8'h01);
    wr(SGT_MISC_OFFSET, 8'hFF);
    rd(SGT_MISC_OFFSET, b); chk(b, 8'h8F);
    // Active rollover 42 -> 3F under wait mode
    @(posedge clk_sys) waitMode <= 1'b1;
    wr(SGT_CTRL_OFFSET, 8'hC2);
    wr(SGT_CTRL_OFFSET, 8'h42);
    rd(SGT_CTRL_OFFSET, b); chk(b[7], 1'b1);
    tolow(200, n); inrange(n, 3 * PRE - 6, 3 * PRE + 2);
    lowlen(n); chk(8'(n), 8'(SGT_PULSE_CYC));
    @(posedge clk_sys) waitMode <= 1'b0;
    doreset();
    chk(8'(guardActive), 8'h00);
    wr(SGT_CTRL_OFFSET, 8'h80);
    tolow(4, n); inrange(n, 0, 2);
    // Hardware option: activation bit clear still resets
    @(posedge clk_sys) hwWatchdogOpt <= 1'b1;
    doreset();
    chk(8'(guardActive), 8'h01);
    wr(SGT_CTRL_OFFSET, 8'h41);
    tolow(200, n); inrange(n, 2 * PRE - 6, 2 * PRE + 2);
    @(posedge clk_sys) hwWatchdogOpt <= 1'b0;
    // Halt policy against USB suspend
    for (int k = 0; k < 4; k++) begin
      doreset();
      usbSuspend <= k[0];
      wr(SGT_MISC_OFFSET, {k[1], 7'h00});
      wr(SGT_CTRL_OFFSET, 8'hFF);
      halt(1'b0);
      tolow(10, n); chk(8'(n < 10), 8'(k == 0));
    end
    @(posedge clk_sys) usbSuspend <= 1'b0;
    // Frozen in halt, resumes after wake-up
    doreset();
    wr(SGT_MISC_OFFSET, 8'h80);
    wr(SGT_CTRL_OFFSET, 8'hC1);
    halt(1'b1);
    tolow(4 * PRE, n); chk(8'(n), 8'(4 * PRE));
    rd(SGT_CTRL_OFFSET, b); chk(b, 8'hC1);
    @(posedge clk_sys) lowPow.extWake <= 1'b1;
    @(posedge clk_sys) lowPow.extWake <= 1'b0;
    tolow(200, n); inrange(n, WAKE + PRE, WAKE + 2 * PRE + 2);
    complete_run();
  end
endmodule

// File: rtl/sgt_guard_timer.sv
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
// Summary of operation
// - Count down once every 65536 cycles.
// - Active: reset when top bit clears.
// - Reset pulse lasts about 500 ns.
// - Countdown runs even when inactive.
// - Software option starts inactive after reset.
// - Activation bit cleared only by reset.
// - Write active with top clear resets.
// - Hardware option: always active, bit ignored.
// - Rollover resets only when activated.
// - Wait mode does not affect the watchdog.
// - Policy zero: halt resets when active unless suspended.
// - Policy one: halt enters halt, no reset.
// - No halt reset during USB suspend.
// - Oscillator stopped: freeze count, no resets.
// - Resume counting 514 clocks after wake.
// - Reset loads control with 7Fh.

// Integration notes
// - The pulse length is counted in system clocks; a different
//   clock rate needs a new cycle count in the package.
// - The block's own reset ends a pulse in flight, so the pin
//   must not feed rst_n without stretching it first.
// - While frozen or waking, writes reload the countdown but
//   cannot start a software reset.
// - The hardware option also lets a write with the top bit
//   clear start a software reset.
// - Prescaler width is fixed at 16 bits; a larger step count
//   would need a wider counter.
module sgt_guard_timer
  import sgt_pkg::*;
#(
  parameter int PRESCALE = SGT_PRESCALE, // Cycles per step
  parameter int WAKE_CLKS = SGT_WAKE_CLKS // Wake restart delay
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic hwWatchdogOpt,
  input wire logic usbSuspend,
  input wire logic waitMode,
  input wire sgt_lowpow_type lowPow,
  output logic resetPinOut_n,
  output logic guardActive
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum {SGT_RUN, SGT_FROZEN, SGT_WAKING} sgt_state_type;

  sgt_state_type state_r; // Low-power sequencer
  logic actBit_r; // Activation bit
  logic [6:0] timer_r; // Countdown value
  logic [7:0] misc_r; // Halt policy and misc bits
  logic [15:0] prescale_r; // Prescaler counter
  logic [9:0] wakeCnt_r; // Wake delay counter
  logic [7:0] pulseCnt_r; // Reset pulse counter
  logic [7:0] lowLen_r; // Low cycles of the pin, checks only
  logic [7:0] regRdata_r; // Read data register
  logic ctrlWr; // Control register write
  logic stepTick; // Countdown step
  logic counting; // Running: neither frozen nor waking
  logic rollover; // 40h to 3Fh transition
  logic haltReset; // HALT caused reset
  logic fire; // Start a reset pulse

  // Wait mode changes nothing here; only a check reads it
  assign ctrlWr = regWrite && (regAddr == SGT_CTRL_OFFSET);
  assign counting = (state_r == SGT_RUN);
  assign guardActive = hwWatchdogOpt || actBit_r;
  assign stepTick = counting && (prescale_r == 16'(PRESCALE - 1));
  assign rollover = stepTick && (timer_r == 7'h40) && !ctrlWr;

  // Halt reset only under policy zero and no suspend
  assign haltReset = lowPow.haltExec && guardActive && !misc_r[SGT_HALTPOL_BIT]
                     && !usbSuspend;

  // Rollover only fires when activated; frozen or waking state blocks rollover and write resets
  always_comb begin
    fire = 1'b0;
    if (counting && guardActive && rollover) begin
      fire = 1'b1;
    end
    if (counting && ctrlWr && (regWdata[SGT_ACT_BIT] || hwWatchdogOpt)
        && !regWdata[SGT_TOP_BIT]) begin
      fire = 1'b1;
    end
    if (haltReset) begin
      fire = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------
  // Cleared on a write so the next step is a full period
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prescale_r <= 16'h0000;
    end else if (ctrlWr) begin
      prescale_r <= 16'h0000;
    end else if (stepTick) begin
      prescale_r <= 16'h0000;
    end else if (counting) begin
      prescale_r <= prescale_r + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Countdown and activation
  // ------------------------------------------------------------
  // Free-running; keeps wrapping through 00h when inactive
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      timer_r <= SGT_CTRL_RESET[6:0];
    end else if (ctrlWr) begin
      timer_r <= regWdata[6:0];
    end else if (stepTick) begin
      timer_r <= timer_r - 7'h01;
    end
  end

  // Sticky once set; only reset clears it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      actBit_r <= SGT_CTRL_RESET[SGT_ACT_BIT];
    end else if (ctrlWr && regWdata[SGT_ACT_BIT]) begin
      actBit_r <= 1'b1;
    end
  end

  // Misc register keeps only implemented bits
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      misc_r <= SGT_MISC_RESET;
    end else if (regWrite && (regAddr == SGT_MISC_OFFSET)) begin
      misc_r <= regWdata & SGT_MISC_KEEP;
    end
  end

  // ------------------------------------------------------------
  // Low-power sequencer
  // ------------------------------------------------------------
  // Halt with stopped oscillator freezes; wake waits out a delay
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= SGT_RUN;
      wakeCnt_r <= 10'h000;
    end else begin
      case (state_r)
        SGT_RUN: begin
          if (lowPow.haltExec && !haltReset && lowPow.oscStop) begin
            state_r <= SGT_FROZEN;
          end
        end
        SGT_FROZEN: begin
          if (lowPow.extWake) begin
            state_r <= SGT_WAKING;
            wakeCnt_r <= 10'h000;
          end
        end
        SGT_WAKING: begin
          if (wakeCnt_r == 10'(WAKE_CLKS - 1)) begin
            state_r <= SGT_RUN;
          end else begin
            wakeCnt_r <= wakeCnt_r + 10'h001;
          end
        end
        default: begin
          state_r <= SGT_RUN;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Reset pulse
  // ------------------------------------------------------------
  // The block's own reset ends a pulse in flight; nothing here
  // loops the pin back to rst_n
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pulseCnt_r <= 8'h00;
    end else if (fire && (pulseCnt_r == 8'h00)) begin
      pulseCnt_r <= 8'(SGT_PULSE_CYC);
    end else if (pulseCnt_r != 8'h00) begin
      pulseCnt_r <= pulseCnt_r - 8'h01;
    end
  end

  assign resetPinOut_n = (pulseCnt_r == 8'h00);

  // ------------------------------------------------------------
  // Pulse length monitor
  // ------------------------------------------------------------
  // Counts low cycles of the pin for the width checks only;
  // a counter is used because the width is too long to spell
  // out as a repetition
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lowLen_r <= 8'h00;
    end else if (!resetPinOut_n) begin
      lowLen_r <= lowLen_r + 8'h01;
    end else begin
      lowLen_r <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // Unmapped addresses read as zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regRdata_r <= 8'h00;
    end else if (regRead && (regAddr == SGT_CTRL_OFFSET)) begin
      regRdata_r <= {actBit_r, timer_r};
    end else if (regRead && (regAddr == SGT_MISC_OFFSET)) begin
      regRdata_r <= misc_r;
    end else begin
      regRdata_r <= 8'h00;
    end
  end

  assign regRdata = regRdata_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Each step follows a full prescaler run; a frozen spell can
  // hold the prescaler at its end, so only steps after a
  // counting cycle are judged
  step_period_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stepTick && $past(counting)) |-> $past(prescale_r) == 16'(PRESCALE - 2))
    else $error("Countdown step not at prescaler end");

  // Armed rollover pulls the pin on the next cycle
  rollover_fires_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rollover && guardActive && pulseCnt_r == 8'h00) |=> !resetPinOut_n)
    else $error("Rollover did not pull reset low");

  // Pulse ends after exactly its count of low cycles
  pulse_width_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(resetPinOut_n) |-> lowLen_r == 8'(SGT_PULSE_CYC))
    else $error("Reset pulse width wrong");

  // Pulse never outlasts its count
  pulse_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lowLen_r <= 8'(SGT_PULSE_CYC))
    else $error("Reset pulse too long");

  // Countdown steps whatever the activation state
  free_running_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stepTick && !ctrlWr) |=> timer_r == $past(timer_r) - 7'h01)
    else $error("Countdown did not step");

  // Activation comes only from a software write
  act_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!actBit_r && !(ctrlWr && regWdata[SGT_ACT_BIT])) |=> !actBit_r)
    else $error("Activation bit set without a write");

  // Activation survives every write
  act_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    actBit_r |=> actBit_r)
    else $error("Activation bit cleared without reset");

  // Write with top bit clear resets at once
  soft_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (counting && ctrlWr && regWdata[SGT_ACT_BIT] && !regWdata[SGT_TOP_BIT] && pulseCnt_r == 8'h00)
    |=> !resetPinOut_n)
    else $error("Software reset not issued");

  // Hardware option keeps the guard armed
  hw_armed_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hwWatchdogOpt |-> guardActive)
    else $error("Hardware option left guard inactive");

  // Disarmed guard never pulls the pin
  inactive_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!guardActive && !ctrlWr && resetPinOut_n) |=> resetPinOut_n)
    else $error("Reset while inactive");

  // Wait mode leaves the countdown stepping
  wait_neutral_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (waitMode && stepTick && !ctrlWr) |=> timer_r == $past(timer_r) - 7'h01)
    else $error("Wait mode disturbed the countdown");

  // Halt under policy one or suspend keeps the pin high
  halt_policy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (lowPow.haltExec && (misc_r[SGT_HALTPOL_BIT] || usbSuspend) && !ctrlWr && !rollover && resetPinOut_n)
    |=> resetPinOut_n)
    else $error("Halt reset despite policy or suspend");

  // Halt under policy zero resets an armed guard
  halt_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (lowPow.haltExec && guardActive && !misc_r[SGT_HALTPOL_BIT] && !usbSuspend && pulseCnt_r == 8'h00)
    |=> !resetPinOut_n)
    else $error("Halt reset missing");

  // Countdown holds while the oscillator is stopped
  frozen_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == SGT_FROZEN && !ctrlWr) |=> timer_r == $past(timer_r))
    else $error("Countdown moved while frozen");

  // No rollover or write reset while not counting
  frozen_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!counting && pulseCnt_r == 8'h00 && !haltReset) |=> resetPinOut_n)
    else $error("Reset while frozen or waking");

  // Counting stays off early in the wake delay
  wake_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == SGT_FROZEN && lowPow.extWake) |=> !counting [*8])
    else $error("Counting resumed too early");

  // Wake delay starts from zero
  wake_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == SGT_FROZEN && lowPow.extWake) |=> (state_r == SGT_WAKING && wakeCnt_r == 10'h000))
    else $error("Wake delay did not start");

  // Wake delay holds until its last count
  wake_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == SGT_WAKING && wakeCnt_r != 10'(WAKE_CLKS - 1)) |=> !counting)
    else $error("Wake delay cut short");

  // Counting resumes right after the last count
  wake_exit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == SGT_WAKING && wakeCnt_r == 10'(WAKE_CLKS - 1)) |=> counting)
    else $error("Wake delay overran");

  // Write reloads countdown and restarts prescaler
  write_reload_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrlWr |=> (prescale_r == 16'h0000) && (timer_r == $past(regWdata[6:0])))
    else $error("Write did not reload the countdown");

  // Read data is zero outside the answer cycle
  read_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(regRead) |-> regRdata == 8'h00)
    else $error("Read data not idle");

endmodule

// File: rtl/sgt_pkg.sv
package sgt_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] SGT_CTRL_OFFSET = 8'h14; // Watchdog control
  localparam logic [7:0] SGT_MISC_OFFSET = 8'h4C; // Halt policy / misc control
  localparam logic [7:0] SGT_CTRL_RESET = 8'h7F; // Inactive, timer all ones
  localparam logic [7:0] SGT_MISC_RESET = 8'h00; // Halt resets when active

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SGT_ACT_BIT = 7; // Activation bit in control
  localparam int SGT_TOP_BIT = 6; // Timer top bit in control
  localparam int SGT_HALTPOL_BIT = 7; // Halt policy bit in misc
  localparam logic [7:0] SGT_MISC_KEEP = 8'h8F; // Implemented misc bits

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int SGT_CLK_MHZ = 100; // System clock rate
  localparam int SGT_PRESCALE = 65536; // Cycles per countdown step
  localparam int SGT_PULSE_NS = 500; // Reset pulse width
  localparam int SGT_PULSE_CYC = (SGT_PULSE_NS * SGT_CLK_MHZ + 999) / 1000; // Rounded up
  localparam int SGT_WAKE_CLKS = 514; // Restart delay after wake-up

  // Halt and wake events from the core
  typedef struct packed {
    logic haltExec; // HALT instruction executed
    logic oscStop; // Oscillator stopped in halt
    logic extWake; // External interrupt wake-up
  } sgt_lowpow_type;

endpackage
